// ==== logic/gcm_map.svh ====
// constants of the glitchless clock mux network
// Behaviour
// - select 0 passes the first clock input, select 1 the second.
// - switching makes no glitch; no high phase shorter than the shortest input high phase.
// - the two clock inputs may be fully unrelated in phase and frequency.
// - plain global buffer drives one clock onto the network with no selection.
// - gated buffer reuses the select mechanism as a glitch-free enable.
// - twenty-four selectors; four top and four bottom reach every quadrant.
// - eight left selectors reach only left quadrants; eight right only right.
// - selectors pair up; one's first input also feeds the neighbour's second.
// - edge selector sources: same-side half-clock pin, double-length lines, clock manager.
// - sixteen global, eight right-half, eight left-half clock pins, also user inputs.
`ifndef GCM_MAP_SVH
`define GCM_MAP_SVH
`define GCM_NUM_SEL      24
`define GCM_NUM_TOP      4
`define GCM_NUM_BOT      4
`define GCM_NUM_LEFT     8
`define GCM_NUM_RIGHT    8
`define GCM_NUM_GPIN     16
`define GCM_NUM_HPIN     8
`define GCM_NUM_QUAD     4
`define GCM_NUM_DL       24
`define GCM_NUM_CM       8
`define GCM_QUAD_ALL     4'hf
`define GCM_QUAD_LEFT    4'h3
`define GCM_QUAD_RIGHT   4'hc
`define GCM_SEL_RST      1'h0
`endif

// ==== logic/gcm_pkg.sv ====
// types of the glitchless clock mux network
package gcm_pkg;
    // one-hot state of one selector
    typedef enum logic [3:0] {
        GCM_RUN_FIRST  = 4'h1,
        GCM_OFF_FIRST  = 4'h2,
        GCM_RUN_SECOND = 4'h4,
        GCM_OFF_SECOND = 4'h8
    } gcm_state_t;

    // source kind feeding an edge switch matrix
    typedef enum logic [1:0] {
        GCM_SRC_PIN  = 2'h0,
        GCM_SRC_DL   = 2'h1,
        GCM_SRC_CM   = 2'h2,
        GCM_SRC_NONE = 2'h3
    } gcm_src_t;

    // per-pair source choice of the switch matrix
    typedef struct packed {
        gcm_src_t   kind_a;
        logic [4:0] idx_a;
        gcm_src_t   kind_b;
        logic [4:0] idx_b;
    } gcm_pair_cfg_t;
endpackage : gcm_pkg

// ==== logic/gcm_network.sv ====
// glitchless clock mux network: switch matrices, paired selectors, quadrant spines
`timescale 1ns/100ps
`include "gcm_map.svh"
module gcm_network (
    // clock and reset
    input  wire logic                          clock,
    input  wire logic                          rst,
    // dedicated clock pins, also readable as user inputs
    input  wire logic [`GCM_NUM_GPIN-1:0]      global_clock_pin,
    input  wire logic [`GCM_NUM_HPIN-1:0]      right_half_clock_pin,
    input  wire logic [`GCM_NUM_HPIN-1:0]      left_half_clock_pin,
    output logic      [2*`GCM_NUM_GPIN-1:0]    user_pin_in,
    // other sources
    input  wire logic [`GCM_NUM_DL-1:0]        double_line,
    input  wire logic [`GCM_NUM_CM-1:0]        clock_manager,
    // switch matrix choice, one per selector pair
    input  wire gcm_pkg::gcm_pair_cfg_t [`GCM_NUM_SEL/2-1:0] pair_cfg,
    // per-selector control: select, or enable in gated mode
    input  wire logic [`GCM_NUM_SEL-1:0]       sel_in,
    input  wire logic [`GCM_NUM_SEL-1:0]       gated_mode,
    input  wire logic [`GCM_NUM_SEL-1:0]       plain_mode,
    // outputs
    output logic      [`GCM_NUM_SEL-1:0]       sel_clock_out,
    output logic      [`GCM_NUM_SEL-1:0]       sel_active_second,
    output logic [`GCM_NUM_QUAD-1:0][`GCM_NUM_SEL-1:0] quad_clock
);

    ////////////////////////////////////////////////////////////////////////////
    // source pick per switch matrix

    localparam int NPAIR = `GCM_NUM_SEL / 2;

    function automatic logic pick_src(input gcm_pkg::gcm_src_t kind, input logic [4:0] idx,
                                      input logic [`GCM_NUM_GPIN-1:0] gp,
                                      input logic [`GCM_NUM_HPIN-1:0] hp,
                                      input logic [`GCM_NUM_DL-1:0]   dl,
                                      input logic [`GCM_NUM_CM-1:0]   cm,
                                      input logic                     edge_sel);
        logic r;
        r = 1'b0;
        if (kind == gcm_pkg::GCM_SRC_PIN) begin
            r = edge_sel ? hp[idx[2:0]] : gp[idx[3:0]];
        end else if (kind == gcm_pkg::GCM_SRC_DL) begin
            if (idx < 5'(`GCM_NUM_DL))
                r = dl[idx]; // out-of-range index reads low
        end else if (kind == gcm_pkg::GCM_SRC_CM) begin
            r = cm[idx[2:0]];
        end
        return r;
    endfunction : pick_src

    // true when a pair sits on the left or right edge and takes half-clock pins
    function automatic logic on_half_edge(input int pair);
        logic r;
        r = 1'b0;
        if (pair >= (`GCM_NUM_TOP + `GCM_NUM_BOT) / 2)
            r = 1'b1;
        return r;
    endfunction : on_half_edge

    // true when a pair sits on the left edge
    function automatic logic on_left_edge(input int pair);
        logic r;
        r = 1'b0;
        if (on_half_edge(pair) && pair < (`GCM_NUM_TOP + `GCM_NUM_BOT + `GCM_NUM_LEFT) / 2)
            r = 1'b1;
        return r;
    endfunction : on_left_edge

    // quadrants reached by one selector
    function automatic logic [`GCM_NUM_QUAD-1:0] reach_of(input int sel);
        logic [`GCM_NUM_QUAD-1:0] r;
        r = `GCM_QUAD_RIGHT;
        if (sel < `GCM_NUM_TOP + `GCM_NUM_BOT) begin
            r = `GCM_QUAD_ALL;
        end else if (sel < `GCM_NUM_TOP + `GCM_NUM_BOT + `GCM_NUM_LEFT) begin
            r = `GCM_QUAD_LEFT;
        end
        return r;
    endfunction : reach_of

    // plain and gated selectors never take the second input
    function automatic logic wants_second(input logic sel, input logic gated, input logic plain);
        logic r;
        r = sel;
        if (gated || plain)
            r = 1'b0;
        return r;
    endfunction : wants_second

    // a selector is off only when gated with its enable low
    function automatic logic wants_on(input logic sel, input logic gated, input logic plain);
        logic r;
        r = 1'b1;
        if (gated && !plain && !sel)
            r = 1'b0;
        return r;
    endfunction : wants_on

    assign user_pin_in = {left_half_clock_pin, right_half_clock_pin, global_clock_pin};

    logic [NPAIR-1:0] mat_a;
    logic [NPAIR-1:0] mat_b;

    ////////////////////////////////////////////////////////////////////////////
    // paired selectors

    genvar p;
    generate
        for (p = 0; p < NPAIR; p++) begin : g_pair
            // pairs 0..1 top, 2..3 bottom, 4..7 left, 8..11 right
            localparam bit IS_LEFT = on_left_edge(p);
            localparam bit IS_HALF = on_half_edge(p);
            logic [`GCM_NUM_HPIN-1:0] half_pins;
            assign half_pins = IS_LEFT ? left_half_clock_pin : right_half_clock_pin;
            assign mat_a[p] = pick_src(pair_cfg[p].kind_a, pair_cfg[p].idx_a, global_clock_pin,
                                       half_pins, double_line, clock_manager,
                                       IS_HALF);
            assign mat_b[p] = pick_src(pair_cfg[p].kind_b, pair_cfg[p].idx_b, global_clock_pin,
                                       half_pins, double_line, clock_manager,
                                       IS_HALF);
        end
    endgenerate

    genvar s;
    generate
        for (s = 0; s < `GCM_NUM_SEL; s++) begin : g_sel
            // neighbours share the matrix crosswise
            logic in_first;
            logic in_second;
            logic want_second;
            logic want_on;
            logic ph_first_reg;
            logic ph_second_reg;
            gcm_pkg::gcm_state_t state_reg;
            gcm_pkg::gcm_state_t state_next;
            logic out_next;

            assign in_first  = (s % 2 == 0) ? mat_a[s/2] : mat_b[s/2];
            assign in_second = (s % 2 == 0) ? mat_b[s/2] : mat_a[s/2];

            // gated mode: select acts as enable; plain mode always runs the first input
            assign want_second = wants_second(sel_in[s], gated_mode[s], plain_mode[s]);
            assign want_on     = wants_on(sel_in[s], gated_mode[s], plain_mode[s]);

            ////////////////////////////////////////////////////////////////////
            // selector state machine

            // each clock phase is sampled on the system clock; the user keeps
            // select steady before the chosen rise so the handover is clean
            always_ff @(posedge clock) begin
                ph_first_reg  <= in_first;
                ph_second_reg <= in_second;
            end

            always_comb begin
                state_next = state_reg;
                case (state_reg)
                    gcm_pkg::GCM_RUN_FIRST: begin
                        if (!plain_mode[s] && (want_second || !want_on) && !ph_first_reg)
                            state_next = gcm_pkg::GCM_OFF_FIRST;
                    end
                    gcm_pkg::GCM_OFF_FIRST: begin
                        if (want_second && !ph_second_reg)
                            state_next = gcm_pkg::GCM_RUN_SECOND;
                        else if (!want_second && want_on && !ph_first_reg)
                            state_next = gcm_pkg::GCM_RUN_FIRST;
                    end
                    gcm_pkg::GCM_RUN_SECOND: begin
                        if ((plain_mode[s] || !want_second) && !ph_second_reg)
                            state_next = gcm_pkg::GCM_OFF_SECOND;
                    end
                    gcm_pkg::GCM_OFF_SECOND: begin
                        if (!ph_first_reg)
                            state_next = gcm_pkg::GCM_OFF_FIRST;
                    end
                    default: state_next = gcm_pkg::GCM_OFF_FIRST;
                endcase
            end

            always_ff @(posedge clock) begin
                if (rst)
                    state_reg <= gcm_pkg::GCM_OFF_FIRST;
                else
                    state_reg <= state_next;
            end

            ////////////////////////////////////////////////////////////////////
            // selector output

            // output is the sampled phase of the running input, low otherwise;
            // the sampled phase is low on entry, so a run never starts mid-high
            always_comb begin
                out_next = 1'b0;
                if (state_next == gcm_pkg::GCM_RUN_FIRST)
                    out_next = ph_first_reg;
                else if (state_next == gcm_pkg::GCM_RUN_SECOND)
                    out_next = ph_second_reg;
            end

            always_ff @(posedge clock) begin
                if (rst)
                    sel_clock_out[s] <= 1'b0;
                else
                    sel_clock_out[s] <= out_next;
            end

            assign sel_active_second[s] = (state_reg == gcm_pkg::GCM_RUN_SECOND);

            ////////////////////////////////////////////////////////////////////
            // quadrant spines

            // quadrant reach: top/bottom all, left half, right half
            localparam logic [`GCM_NUM_QUAD-1:0] REACH = reach_of(s);
            genvar q;
            for (q = 0; q < `GCM_NUM_QUAD; q++) begin : g_q
                assign quad_clock[q][s] = REACH[q] & sel_clock_out[s];
            end
        end
    endgenerate

endmodule : gcm_network

// ==== testbench/gcm_network_sva.sv ====
// checker of the clock mux network outputs
`timescale 1ns/100ps
module gcm_network_chk (
    // control
    input wire logic             clock,
    input wire logic             rst,
    input wire logic [23:0]      sel_in,
    input wire logic [23:0]      gated_mode,
    input wire logic [23:0]      plain_mode,
    // outputs
    input wire logic [23:0]      sel_clock_out,
    input wire logic [23:0]      sel_active_second,
    input wire logic [3:0][23:0] quad_clock
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    AST_QUAD_TOP: assert property (quad_clock[3][7:0] == sel_clock_out[7:0])
        else $error("top spine differs");
    AST_QUAD_LEFT: assert property (quad_clock[1][15:8] == sel_clock_out[15:8] &&
        quad_clock[2][15:8] == 8'h00) else $error("left spine reach wrong");
    AST_QUAD_RIGHT: assert property (quad_clock[3][23:16] == sel_clock_out[23:16] &&
        quad_clock[0][23:16] == 8'h00) else $error("right spine reach wrong");
    AST_RST_LOW: assert property (disable iff (1'b0) rst |=> sel_clock_out == 24'h0)
        else $error("output not low after reset");
    AST_PLAIN_FIRST: assert property ($rose(plain_mode[4]) |-> ##[1:60] !sel_active_second[4])
        else $error("plain buffer kept second input");
    AST_SWITCH_LOW: assert property ($changed(sel_active_second[0]) |-> !sel_clock_out[0])
        else $error("output high at switch over");
    AST_SEL_CAUSE: assert property ($rose(sel_active_second[0]) |-> $past(sel_in[0]))
        else $error("second input taken without select");
    AST_SWITCH_BOUND: assert property ($rose(sel_in[0]) && !gated_mode[0] && !plain_mode[0]
        |-> ##[1:60] (sel_active_second[0] || !sel_in[0])) else $error("switch never done");
    cover property ($rose(sel_active_second[0]));
    cover property ($fell(sel_active_second[0]));
    cover property ($rose(sel_clock_out[16]));
endmodule : gcm_network_chk
bind gcm_network gcm_network_chk chk_u (.clock(clock), .rst(rst), .sel_in(sel_in),
    .gated_mode(gated_mode), .plain_mode(plain_mode), .sel_clock_out(sel_clock_out),
    .sel_active_second(sel_active_second), .quad_clock(quad_clock));

// ==== testbench/gcm_user_model.sv ====
// user side model: two unrelated source clocks and a select driver
`timescale 1ns/100ps
module gcm_user_model (
    // system clock and run control
    input  wire logic clock,
    input  wire logic active,
    // sources and select
    output logic      src_a,
    output logic      src_b,
    output logic      sel
);
    initial begin
        {src_a, src_b, sel} = 3'h0;
        fork
            #3 forever #54 src_a = ~src_a;
            #7 forever #84 src_b = ~src_b;
        join
    end
    // select moves only just after a rise of the selected source
    always begin
        if (sel) @(posedge src_b); else @(posedge src_a);
        @(negedge clock);
        if (active && $urandom_range(1) == 1) sel <= ~sel;
    end
endmodule : gcm_user_model

// ==== testbench/gcm_network_bench.sv ====
// self-checking bench of the glitchless clock mux network
`timescale 1ns/100ps
module gcm_network_bench;
    logic                         clock, rst, src_a, src_b, psel, rnd, chk, sa, sb;
    logic [23:0]                  out, act;
    logic [31:0]                  upin, pins;
    logic [3:0][23:0]             quad;
    gcm_pkg::gcm_pair_cfg_t [11:0] cfg;
    logic [55:0]                  q[$];
    logic [55:0]                  e;
    int                           n_errors = 0, num_checks = 0, m = 0;
    gcm_user_model user_u (.clock(clock), .active(rnd), .src_a(src_a), .src_b(src_b), .sel(psel));
    gcm_network dut_u (.clock(clock), .rst(rst),
        .global_clock_pin({pins[15:2], src_b, src_a}), .right_half_clock_pin({pins[23:18], src_b, src_a}),
        .left_half_clock_pin({pins[31:26], src_b, src_a}), .user_pin_in(upin),
        .double_line({pins[23:1], src_b}), .clock_manager({pins[7:1], src_b}), .pair_cfg(cfg),
        .sel_in({{23{m >= 1 && m <= 3}}, rnd ? psel : (m >= 1 && m <= 3)}),
        .gated_mode({24{m >= 3 && m < 5}}), .plain_mode({24{m == 2}}),
        .sel_clock_out(out), .sel_active_second(act), .quad_clock(quad));
    function automatic logic [23:0] exp_out(int md, logic a, logic b);
        for (int i = 0; i < 24; i++) exp_out[i] = (md == 4) ? 1'b0 : ((md == 1) ^ i[0]) ? b : a;
    endfunction : exp_out
    task automatic check(string what, logic [31:0] seen, logic [31:0] want);
        num_checks++;
        if (seen !== want) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
        end
    endtask : check
    task automatic wrap_up;
        if (n_errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock) {sa, sb} <= {src_a, src_b};
    always @(negedge clock) begin
        pins = $urandom;
        if (chk) q.push_back({pins, exp_out(m, sa, sb)});
    end
    always @(posedge clock) begin
        #1;
        if (q.size() > 0) begin
            e = q.pop_front();
            check("clock out", {8'h00, out}, {8'h00, e[23:0]});
            check("user pins", upin & 32'hfcfc_fffc, e[55:24] & 32'hfcfc_fffc);
        end
    end
    initial begin
        #15000;
        n_errors++;
        wrap_up();
    end
    initial begin
        void'($urandom(32'h67fd));
        {rst, chk, rnd} = 3'h4;
        pins = 32'h0;
        for (int k = 0; k < 12; k++)
            cfg[k] = '{gcm_pkg::GCM_SRC_PIN, 5'h00, gcm_pkg::gcm_src_t'(k % 3), 5'((k % 3) == 0)};
        repeat (5) @(negedge clock);
        rst = 1'b0;
        for (int k = 0; k < 6; k++) begin
            @(negedge clock);
            m = k;
            rnd = (k == 5);
            repeat (60) @(negedge clock);
            chk = (k < 5);
            repeat (k < 5 ? 60 : 600) @(negedge clock);
            chk = 1'b0;
        end
        repeat (4) @(negedge clock);
        wrap_up();
    end
endmodule : gcm_network_bench
